// File: itp_pkg.sv
// Package of constants for the interval timer programming front end
package itp_pkg;
  // Bus port codes
  localparam logic [1:0] PORT_CNT0 = 2'h0;
  localparam logic [1:0] PORT_CNT1 = 2'h1;
  localparam logic [1:0] PORT_CNT2 = 2'h2;
  localparam logic [1:0] PORT_CTRL = 2'h3;
  // Configuration word fields
  localparam int CW_SEL_HI = 7;
  localparam int CW_SEL_LO = 6;
  localparam int CW_FMT_HI = 5;
  localparam int CW_FMT_LO = 4;
  localparam int CW_MODE_HI = 3;
  localparam int CW_MODE_LO = 1;
  localparam int CW_BCD = 0;
  localparam logic [1:0] SEL_READBACK = 2'h3;
  // Access formats
  localparam logic [1:0] FMT_LATCH = 2'h0;
  localparam logic [1:0] FMT_LOW   = 2'h1;
  localparam logic [1:0] FMT_HIGH  = 2'h2;
  localparam logic [1:0] FMT_BOTH  = 2'h3;
  // Reset values
  localparam logic [7:0]  CW_RESET  = 8'h00;
  localparam logic [15:0] CNT_RESET = 16'h0000;
  // Decoded waveform modes
  typedef enum logic [2:0] {
    MODE0, MODE1, MODE2, MODE3, MODE4, MODE5
  } itp_mode_e;
endpackage

// File: itp_counter.sv
// One down-counting element with binary or BCD decrement
`timescale 1ns/1ns
module itp_counter #(
  parameter int WIDTH = 16
) (
  input  wire logic             clk,
  input  wire logic             rst_n,
  input  wire logic             clear,
  input  wire logic             load,
  input  wire logic [WIDTH-1:0] load_val,
  input  wire logic             bcd,
  input  wire logic             enable,
  output logic      [WIDTH-1:0] count_q
);
  localparam int DIGITS = WIDTH / 4;

  // BCD decrement over all decades
  function automatic logic [WIDTH-1:0] bcd_dec(input logic [WIDTH-1:0] v);
    logic [WIDTH-1:0] r;
    logic             borrow;
    r = v;
    borrow = 1'b1;
    for (int i = 0; i < DIGITS; i++) begin
      if (borrow) begin
        if (v[i*4 +: 4] == 4'h0) begin
          r[i*4 +: 4] = 4'h9;
        end else begin
          r[i*4 +: 4] = v[i*4 +: 4] - 4'h1;
          borrow = 1'b0;
        end
      end
    end
    return r;
  endfunction

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      count_q <= '0;
    end else if (clear) begin
      count_q <= '0;
    end else if (load) begin
      count_q <= load_val;
    end else if (enable) begin
      // Zero wraps to all ones or 9999, i.e. full count
      count_q <= bcd ? bcd_dec(count_q) : count_q - 1'b1;
    end
  end
endmodule

// File: itp_front.sv
// Bus decode, configuration and count loading for three timer counters
//
// How it works
// - Selected write stores byte to counter 0,1,2 or configuration word.
// - Selected read drives addressed counter's readable value on data bus.
// - Chip select high: bus undriven, strobes ignored.
// - Select field picks counter 0..2; code 11 is read-back, not configuration.
// - Format field: latch, low only, high only, low then high.
// - Mode field decoded 0..5, top bit ignored for modes 2 and 3.
// - BCD bit zero counts binary, one counts four BCD decades.
// - Configuring clears counter; reads return the cleared count register until a new count loads.
// - Each counter tracks its own low/high write progress.
// - Initial count zero means full count 10000H or BCD 10000.
// - Written count moves into counting element on next clock, then counts.
// - Deselected cycles keep configuration and count registers unchanged; enabled counting elements keep counting.
`timescale 1ns/1ns
module itp_front #(
  parameter int NCNT = 3
) (
  input  wire logic        ref_clk,
  input  wire logic        reset_n,
  input  wire logic        chip_sel_n,
  input  wire logic        rd_n,
  input  wire logic        wr_n,
  input  wire logic        port_select_low,
  input  wire logic        port_select_high,
  input  wire logic [7:0]  data_in,
  output logic      [7:0]  data_out,
  output logic             data_oe_n,
  input  wire logic [2:0]  cnt_enable,
  output logic      [47:0] count_value,
  output logic      [8:0]  wave_mode,
  output logic      [2:0]  count_bcd
);
  //****************************************
  // Reset release
  //****************************************
  logic rst_meta_q;
  logic rst_n_q;
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      rst_meta_q <= 1'b0;
      rst_n_q    <= 1'b0;
    end else begin
      rst_meta_q <= 1'b1;
      rst_n_q    <= rst_meta_q;
    end
  end

  //****************************************
  // Decoding helpers
  //****************************************
  function automatic itp_pkg::itp_mode_e mode_dec(input logic [2:0] m);
    if (m[1]) begin
      return m[0] ? itp_pkg::MODE3 : itp_pkg::MODE2;
    end
    case (m)
      3'h0:    return itp_pkg::MODE0;
      3'h1:    return itp_pkg::MODE1;
      3'h4:    return itp_pkg::MODE4;
      default: return itp_pkg::MODE5;
    endcase
  endfunction

  //****************************************
  // Strobe decode, edge detected on write
  //****************************************
  logic [1:0] port;
  logic       sel_wr;
  logic       sel_rd;
  logic       wr_seen_q;
  logic       wr_pulse;
  logic       rd_seen_q;
  logic       rd_end;
  assign port   = {port_select_high, port_select_low};
  assign sel_wr = !chip_sel_n && !wr_n && rd_n;
  assign sel_rd = !chip_sel_n && !rd_n && wr_n
                  && port != itp_pkg::PORT_CTRL;
  assign wr_pulse = sel_wr && !wr_seen_q;
  assign rd_end   = rd_seen_q && !sel_rd;

  always_ff @(posedge ref_clk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      wr_seen_q <= 1'b0;
      rd_seen_q <= 1'b0;
    end else begin
      wr_seen_q <= sel_wr;
      rd_seen_q <= sel_rd;
    end
  end

  logic [7:0] cw;
  logic       cw_wr;
  assign cw    = data_in;
  assign cw_wr = wr_pulse && port == itp_pkg::PORT_CTRL
                 && cw[itp_pkg::CW_SEL_HI:itp_pkg::CW_SEL_LO]
                    != itp_pkg::SEL_READBACK;

  //****************************************
  // Per-counter state
  //****************************************
  logic [1:0]  fmt_q    [NCNT];
  logic [2:0]  mode_q   [NCNT];
  logic        bcd_q    [NCNT];
  logic [15:0] cr_q     [NCNT];
  logic        wr_hi_q  [NCNT];
  logic        rd_hi_q  [NCNT];
  logic        load_q   [NCNT];
  logic        loaded_q [NCNT];
  logic        latched_q[NCNT];
  logic [15:0] ol_q     [NCNT];
  logic [15:0] ce       [NCNT];
  logic [7:0]  rd_byte  [NCNT];

  genvar g;
  generate
    for (g = 0; g < NCNT; g++) begin : g_cnt
      logic cfg_hit;
      logic cnt_wr;
      logic latch_cmd;
      assign cfg_hit = cw_wr
        && cw[itp_pkg::CW_SEL_HI:itp_pkg::CW_SEL_LO] == 2'(g);
      assign latch_cmd = cfg_hit
        && cw[itp_pkg::CW_FMT_HI:itp_pkg::CW_FMT_LO]
           == itp_pkg::FMT_LATCH;
      assign cnt_wr = wr_pulse && port == 2'(g);

      // Configuration fields
      always_ff @(posedge ref_clk or negedge rst_n_q) begin
        if (!rst_n_q) begin
          fmt_q[g]  <= itp_pkg::CW_RESET[5:4];
          mode_q[g] <= itp_pkg::CW_RESET[3:1];
          bcd_q[g]  <= itp_pkg::CW_RESET[0];
        end else if (cfg_hit && !latch_cmd) begin
          fmt_q[g]  <= cw[itp_pkg::CW_FMT_HI:itp_pkg::CW_FMT_LO];
          mode_q[g] <= cw[itp_pkg::CW_MODE_HI:itp_pkg::CW_MODE_LO];
          bcd_q[g]  <= cw[itp_pkg::CW_BCD];
        end
      end

      // Count register, write progress and load request
      always_ff @(posedge ref_clk or negedge rst_n_q) begin
        if (!rst_n_q) begin
          cr_q[g]    <= itp_pkg::CNT_RESET;
          wr_hi_q[g] <= 1'b0;
          load_q[g]  <= 1'b0;
        end else begin
          load_q[g] <= 1'b0;
          if (cfg_hit && !latch_cmd) begin
            cr_q[g]    <= itp_pkg::CNT_RESET;
            wr_hi_q[g] <= 1'b0;
          end else if (cnt_wr) begin
            case (fmt_q[g])
              itp_pkg::FMT_LOW: begin
                cr_q[g]   <= {8'h00, data_in};
                load_q[g] <= 1'b1;
              end
              itp_pkg::FMT_HIGH: begin
                cr_q[g]   <= {data_in, 8'h00};
                load_q[g] <= 1'b1;
              end
              itp_pkg::FMT_BOTH: begin
                if (wr_hi_q[g]) begin
                  cr_q[g][15:8] <= data_in;
                  load_q[g]     <= 1'b1;
                end else begin
                  cr_q[g][7:0] <= data_in;
                end
                wr_hi_q[g] <= !wr_hi_q[g];
              end
              default: ;
            endcase
          end
        end
      end

      // A loaded count of zero decrements to full scale
      itp_counter #(
        .WIDTH (16)
      ) u_ce (
        .clk      (ref_clk),
        .rst_n    (rst_n_q),
        .clear    (cfg_hit && !latch_cmd),
        .load     (load_q[g]),
        .load_val (cr_q[g]),
        .bcd      (bcd_q[g]),
        .enable   (cnt_enable[g] && loaded_q[g]),
        .count_q  (ce[g])
      );

      // Output latch and read progress
      always_ff @(posedge ref_clk or negedge rst_n_q) begin
        if (!rst_n_q) begin
          loaded_q[g]  <= 1'b0;
          latched_q[g] <= 1'b0;
          ol_q[g]      <= itp_pkg::CNT_RESET;
          rd_hi_q[g]   <= 1'b0;
        end else begin
          if (cfg_hit && !latch_cmd) begin
            loaded_q[g] <= 1'b0;
            rd_hi_q[g]  <= 1'b0;
          end else if (load_q[g]) begin
            loaded_q[g] <= 1'b1;
          end
          if (latch_cmd && !latched_q[g]) begin
            ol_q[g]      <= ce[g];
            latched_q[g] <= 1'b1;
          end else if (rd_end && port == 2'(g)) begin
            if (fmt_q[g] == itp_pkg::FMT_BOTH) begin
              rd_hi_q[g] <= !rd_hi_q[g];
              if (rd_hi_q[g]) begin
                latched_q[g] <= 1'b0;
              end
            end else begin
              latched_q[g] <= 1'b0;
            end
          end
        end
      end

      logic [15:0] view;
      assign view = !loaded_q[g] ? cr_q[g] :
                    latched_q[g] ? ol_q[g] : ce[g];
      assign rd_byte[g] =
        (fmt_q[g] == itp_pkg::FMT_HIGH ||
         (fmt_q[g] == itp_pkg::FMT_BOTH && rd_hi_q[g])) ?
        view[15:8] : view[7:0];

      always_ff @(posedge ref_clk or negedge rst_n_q) begin
        if (!rst_n_q) begin
          count_value[g*16 +: 16] <= itp_pkg::CNT_RESET;
          wave_mode[g*3 +: 3]     <= 3'h0;
          count_bcd[g]            <= 1'b0;
        end else begin
          count_value[g*16 +: 16] <= ce[g];
          wave_mode[g*3 +: 3]     <= 3'(mode_dec(mode_q[g]));
          count_bcd[g]            <= bcd_q[g];
        end
      end
    end
  endgenerate

  //****************************************
  // Data bus drive
  //****************************************
  always_ff @(posedge ref_clk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      data_out  <= 8'h00;
      data_oe_n <= 1'b1;
    end else begin
      data_oe_n <= !sel_rd;
      data_out  <= sel_rd ? rd_byte[port] : 8'h00;
    end
  end

  //****************************************
  // Checks
  //****************************************
  property p_desel_quiet;
    @(posedge ref_clk) disable iff (!rst_n_q)
      chip_sel_n |=> data_oe_n;
  endproperty
  a_desel_quiet: assert property (p_desel_quiet)
    else $error("bus driven while deselected");

  property p_ctrl_read;
    @(posedge ref_clk) disable iff (!rst_n_q)
      (!rd_n && port == itp_pkg::PORT_CTRL) |=> data_oe_n;
  endproperty
  a_ctrl_read: assert property (p_ctrl_read)
    else $error("control port read drove bus");

  property p_read_drive;
    @(posedge ref_clk) disable iff (!rst_n_q)
      sel_rd |=> !data_oe_n && data_out == $past(rd_byte[port]);
  endproperty
  a_read_drive: assert property (p_read_drive)
    else $error("read data wrong");

  sequence s_low_write;
    wr_pulse && port == itp_pkg::PORT_CNT0
      && fmt_q[0] == itp_pkg::FMT_LOW;
  endsequence
  property p_load_next;
    @(posedge ref_clk) disable iff (!rst_n_q)
      s_low_write |=> load_q[0] ##1 ce[0] == {8'h00, $past(data_in, 2)};
  endproperty
  a_load_next: assert property (p_load_next)
    else $error("count not loaded next clock");

  property p_cfg_clear;
    @(posedge ref_clk) disable iff (!rst_n_q)
      (cw_wr && cw[7:6] == 2'h1 && cw[5:4] != itp_pkg::FMT_LATCH)
        |=> ce[1] == 16'h0000 && !loaded_q[1];
  endproperty
  a_cfg_clear: assert property (p_cfg_clear)
    else $error("configuration did not clear counter");

  property p_readback_ignored;
    @(posedge ref_clk) disable iff (!rst_n_q)
      (wr_pulse && port == itp_pkg::PORT_CTRL && data_in[7:6] == 2'h3)
        |=> $stable(mode_q[0]) && $stable(mode_q[1]) && $stable(mode_q[2]);
  endproperty
  a_readback_ignored: assert property (p_readback_ignored)
    else $error("read-back changed configuration");

  property p_desel_hold;
    @(posedge ref_clk) disable iff (!rst_n_q)
      chip_sel_n |=> $stable(cr_q[2]) && $stable(fmt_q[2]);
  endproperty
  a_desel_hold: assert property (p_desel_hold)
    else $error("state changed while deselected");

  property p_two_byte;
    @(posedge ref_clk) disable iff (!rst_n_q)
      (wr_pulse && port == itp_pkg::PORT_CNT2 && fmt_q[2] == itp_pkg::FMT_BOTH
       && !cw_wr) |=> wr_hi_q[2] != $past(wr_hi_q[2]) && $stable(wr_hi_q[0]);
  endproperty
  a_two_byte: assert property (p_two_byte)
    else $error("byte progress not independent");
endmodule

// File: itp_host_model.sv
// Processor-side bus model that drives the timer front end
`timescale 1ns/1ns
module itp_host_model (
  input  wire logic       ref_clk,
  output logic            chip_sel_n,
  output logic            rd_n,
  output logic            wr_n,
  output logic            port_select_low,
  output logic            port_select_high,
  output logic [7:0]      data_in,
  input  wire logic [7:0] data_out,
  input  wire logic       data_oe_n
);
  initial begin
    chip_sel_n = 1'b1;
    rd_n = 1'b1;
    wr_n = 1'b1;
    port_select_low = 1'b0;
    port_select_high = 1'b0;
    data_in = 8'h00;
  end

  // One bus cycle held over two edges; released bus shows inverted data
  task automatic access(input logic cs_n, input logic r_n,
                        input logic w_n, input logic [1:0] port,
                        input logic [7:0] dat, output logic [7:0] rdat,
                        output logic oe_n);
    @(posedge ref_clk);
    chip_sel_n <= cs_n;
    rd_n <= r_n;
    wr_n <= w_n;
    {port_select_high, port_select_low} <= port;
    data_in <= dat;
    @(posedge ref_clk);
    #1;
    rdat = data_out;
    oe_n = data_oe_n;
    @(posedge ref_clk);
    chip_sel_n <= 1'b1;
    rd_n <= 1'b1;
    wr_n <= 1'b1;
    data_in <= ~dat;
  endtask
endmodule

// File: tb_top.sv
// Self-checking bench for the timer programming front end
`timescale 1ns/1ns
module tb_top;
  logic        ref_clk;
  logic        reset_n;
  logic        chip_sel_n;
  logic        rd_n;
  logic        wr_n;
  logic        port_select_low;
  logic        port_select_high;
  logic [7:0]  data_in;
  logic [7:0]  data_out;
  logic        data_oe_n;
  logic [2:0]  cnt_enable;
  logic [47:0] count_value;
  logic [8:0]  wave_mode;
  logic [2:0]  count_bcd;
  logic [7:0]  rd_byte;
  logic        rd_oe_n;
  int          bad_count;
  int          samples_checked;
  logic [2:0]  mode_tab [8] = '{3'h0, 3'h1, 3'h2, 3'h3,
                                3'h4, 3'h5, 3'h2, 3'h3};

  itp_front #(.NCNT(3)) dut_u (
    .ref_clk(ref_clk), .reset_n(reset_n), .chip_sel_n(chip_sel_n),
    .rd_n(rd_n), .wr_n(wr_n), .port_select_low(port_select_low),
    .port_select_high(port_select_high), .data_in(data_in),
    .data_out(data_out), .data_oe_n(data_oe_n), .cnt_enable(cnt_enable),
    .count_value(count_value), .wave_mode(wave_mode),
    .count_bcd(count_bcd));

  itp_host_model host_u (
    .ref_clk(ref_clk), .chip_sel_n(chip_sel_n), .rd_n(rd_n),
    .wr_n(wr_n), .port_select_low(port_select_low),
    .port_select_high(port_select_high), .data_in(data_in),
    .data_out(data_out), .data_oe_n(data_oe_n));

  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end

  task automatic check(input string what, input logic [47:0] seen,
                       input logic [47:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      bad_count++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic wr(input logic [1:0] port, input logic [7:0] dat);
    host_u.access(1'b0, 1'b1, 1'b0, port, dat, rd_byte, rd_oe_n);
  endtask

  task automatic rd(input logic [1:0] port, input logic [7:0] exp);
    host_u.access(1'b0, 1'b0, 1'b1, port, 8'h00, rd_byte, rd_oe_n);
    check("read enable", {47'h0, rd_oe_n}, 48'h0);
    check("read byte", {40'h0, rd_byte}, {40'h0, exp});
  endtask

  // Cycle that must neither drive the bus nor change any state
  task automatic refused(input logic cs_n, input logic r_n,
                         input logic w_n, input logic [1:0] port);
    logic [47:0] cnt;
    logic [11:0] cfg;
    @(posedge ref_clk);
    #1;
    cnt = count_value;
    cfg = {wave_mode, count_bcd};
    host_u.access(cs_n, r_n, w_n, port, 8'hC2, rd_byte, rd_oe_n);
    repeat (3) @(posedge ref_clk);
    #1;
    check("idle enable", {47'h0, rd_oe_n}, 48'h1);
    check("count kept", count_value, cnt);
    check("config kept", {36'h0, wave_mode, count_bcd}, {36'h0, cfg});
  endtask

  task automatic wrap_up();
    $display("checks %0d mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  initial begin
    #500000;
    bad_count++;
    wrap_up();
  end

  initial begin
    cnt_enable = 3'h0;
    reset_n = 1'b0;
    bad_count = 0;
    samples_checked = 0;
    repeat (12) @(posedge ref_clk);
    #1;
    check("reset counts", count_value, 48'h0);
    check("reset outputs", {35'h0, data_oe_n, wave_mode, count_bcd},
          48'h1000);
    @(posedge ref_clk);
    reset_n <= 1'b1;
    repeat (4) @(posedge ref_clk);
    $display("test reset done");
    // ****************************************
    // Programming sequence with interleaving
    // ****************************************
    wr(itp_pkg::PORT_CTRL, 8'h1E);
    wr(itp_pkg::PORT_CTRL, 8'h6A);
    wr(itp_pkg::PORT_CTRL, 8'hB1);
    @(posedge ref_clk);
    #1;
    check("modes", {36'h0, wave_mode, count_bcd}, {36'h0, 9'h02B, 3'h4});
    wr(itp_pkg::PORT_CNT2, 8'h34);
    fork
      wr(itp_pkg::PORT_CNT0, 8'h03);
      begin
        repeat (2) @(posedge ref_clk);
        #2;
        check("not loaded", {16'h0, count_value[31:0]}, 48'h0);
      end
    join
    wr(itp_pkg::PORT_CNT1, 8'hAA);
    wr(itp_pkg::PORT_CNT2, 8'h12);
    repeat (3) @(posedge ref_clk);
    #1;
    check("loaded", count_value, 48'h1234_AA00_0003);
    rd(itp_pkg::PORT_CNT0, 8'h03);
    rd(itp_pkg::PORT_CNT1, 8'hAA);
    rd(itp_pkg::PORT_CNT2, 8'h34);
    rd(itp_pkg::PORT_CNT2, 8'h12);
    $display("test programming done");
    // ****************************************
    // Refused cycles
    // ****************************************
    refused(1'b1, 1'b1, 1'b0, itp_pkg::PORT_CNT0);
    refused(1'b1, 1'b0, 1'b1, itp_pkg::PORT_CNT0);
    refused(1'b0, 1'b0, 1'b1, itp_pkg::PORT_CTRL);
    refused(1'b0, 1'b1, 1'b1, itp_pkg::PORT_CNT1);
    refused(1'b0, 1'b0, 1'b0, itp_pkg::PORT_CNT2);
    refused(1'b0, 1'b1, 1'b0, itp_pkg::PORT_CTRL);
    $display("test refusals done");
    // ****************************************
    // Every mode code on counter 1
    // ****************************************
    for (int m = 0; m < 8; m++) begin
      wr(itp_pkg::PORT_CTRL, 8'h50 | 8'(m << 1));
      @(posedge ref_clk);
      #1;
      check("mode", {45'h0, wave_mode[5:3]}, {45'h0, mode_tab[m]});
      check("cleared", {32'h0, count_value[31:16]}, 48'h0);
    end
    $display("test modes done");
    // ****************************************
    // Full count, decades and latch
    // ****************************************
    wr(itp_pkg::PORT_CTRL, 8'h10);
    wr(itp_pkg::PORT_CTRL, 8'h91);
    wr(itp_pkg::PORT_CNT0, 8'h00);
    wr(itp_pkg::PORT_CNT2, 8'h00);
    repeat (3) @(posedge ref_clk);
    cnt_enable <= 3'h5;
    @(posedge ref_clk);
    cnt_enable <= 3'h0;
    // Count outputs trail the counting elements by one clock
    @(posedge ref_clk);
    #1;
    check("wrap", {16'h0, count_value[47:32], count_value[15:0]},
          48'h0000_9999_FFFF);
    wr(itp_pkg::PORT_CTRL, 8'h00);
    cnt_enable <= 3'h1;
    @(posedge ref_clk);
    cnt_enable <= 3'h0;
    rd(itp_pkg::PORT_CNT0, 8'hFF);
    rd(itp_pkg::PORT_CNT0, 8'hFE);
    $display("test count range done");
    wrap_up();
  end
endmodule
